/* File: logic/ofc_params.svh */
// offsets, field positions, reset values and counts of the output fetch control block
`ifndef OFC_PARAMS_SVH
`define OFC_PARAMS_SVH

// register byte addresses
`define OFC_ADDR_W 12
`define OFC_MASK_OFF 12'h710
`define OFC_CMD_OFF 12'h714
`define OFC_ERR_STAT_OFF 12'h720
`define OFC_ERR_CLR_OFF 12'h724
`define OFC_ERR_EN_OFF 12'h728
`define OFC_FIFO_FIRST_OFF 12'h72C
`define OFC_PAY_BASE 12'h600
`define OFC_HDR_BASE 12'h700

// command request fields
`define OFC_NUM_W 7
`define OFC_VIEW_BIT 8
`define OFC_REQ_BIT 9
`define OFC_BUSY_BIT 15
`define OFC_HOST_NUM_LSB 16

// fetch mask fields
`define OFC_HDR_SH_BIT 0
`define OFC_PAY_SH_BIT 1
`define OFC_HDR_HOST_BIT 16
`define OFC_PAY_HOST_BIT 17

// error status fields
`define OFC_ERR_W 2
`define OFC_ERR_ILLEGAL_BIT 0
`define OFC_ERR_DONE_BIT 1

// reset values and sizes
`define OFC_REG_RST 32'h0000_0000
`define OFC_FIFO_FIRST_RST 7'h7F
`define OFC_HDR_WORDS 3
`define OFC_PAY_WORDS 64
`define OFC_IDX_W 7

// bus answers
`define OFC_RESP_OKAY 2'h0
`define OFC_RESP_DECERR 2'h3

`endif

/* File: logic/ofc_pkg.sv */
// types shared by the output fetch control block
package ofc_pkg;

  // copy sequencer states
  typedef enum logic [1:0] {
    OFC_IDLE,
    OFC_HDR,
    OFC_PAY,
    OFC_FIN
  } ofc_state_t;

  // one fetch request handed to the copy sequencer
  typedef struct packed {
    logic [6:0] buf_num;
    logic rd_hdr;
    logic rd_pay;
  } ofc_xfer_t;

  // one word written into the shadow half
  typedef struct packed {
    logic we;
    logic [6:0] idx;
    logic [31:0] data;
  } ofc_stage_wr_t;

endpackage : ofc_pkg

/* File: logic/ofc_copy_engine.sv */
// copy sequencer: reads one message buffer and streams it into the shadow half
`timescale 1ns/1ps
`include "ofc_params.svh"

module ofc_copy_engine #(
  parameter int HDR_WORDS = `OFC_HDR_WORDS,
  parameter int PAY_WORDS = `OFC_PAY_WORDS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request
  input wire logic start,
  input wire ofc_pkg::ofc_xfer_t xfer,
  // message memory read port, data one cycle after the strobe
  output logic mem_rd_en,
  output logic [6:0] mem_rd_buf,
  output logic [6:0] mem_rd_word,
  input wire logic [31:0] mem_rd_data,
  // shadow half write and completion
  output ofc_pkg::ofc_stage_wr_t stage_wr,
  output logic done,
  output logic hdr_clr,
  output logic pay_clr
);

  localparam int CL = HDR_WORDS + PAY_WORDS + 1;

  ofc_pkg::ofc_state_t state_q, state_d;
  ofc_pkg::ofc_xfer_t xfer_q, xfer_d;
  logic [6:0] cnt_q, cnt_d;
  logic pend_q, pend_d;
  logic [6:0] pend_idx_q, pend_idx_d;

  // data lands one cycle after its read strobe
  assign stage_wr = '{we: pend_q, idx: pend_idx_q, data: mem_rd_data};
  assign mem_rd_buf = xfer_q.buf_num;

  // sequencing: header words first, then payload, then one finishing cycle
  always_comb begin
    state_d = state_q;
    xfer_d = xfer_q;
    cnt_d = cnt_q;
    pend_d = 1'b0;
    pend_idx_d = pend_idx_q;
    mem_rd_en = 1'b0;
    mem_rd_word = 7'h00;
    done = 1'b0;
    hdr_clr = 1'b0;
    pay_clr = 1'b0;
    case (state_q)
      ofc_pkg::OFC_IDLE: begin
        if (start) begin
          xfer_d = xfer;
          cnt_d = 7'h00;
          if (xfer.rd_hdr) begin
            state_d = ofc_pkg::OFC_HDR;
          end else if (xfer.rd_pay) begin
            state_d = ofc_pkg::OFC_PAY;
          end else begin
            state_d = ofc_pkg::OFC_FIN;
          end
        end
      end
      ofc_pkg::OFC_HDR: begin
        mem_rd_en = 1'b1;
        mem_rd_word = cnt_q;
        pend_d = 1'b1;
        pend_idx_d = cnt_q;
        if (cnt_q == 7'(HDR_WORDS - 1)) begin
          cnt_d = 7'h00;
          state_d = xfer_q.rd_pay ? ofc_pkg::OFC_PAY : ofc_pkg::OFC_FIN;
        end else begin
          cnt_d = cnt_q + 7'h01;
        end
      end
      ofc_pkg::OFC_PAY: begin
        mem_rd_en = 1'b1;
        mem_rd_word = 7'(HDR_WORDS) + cnt_q;
        pend_d = 1'b1;
        pend_idx_d = 7'(HDR_WORDS) + cnt_q;
        if (cnt_q == 7'(PAY_WORDS - 1)) begin
          cnt_d = 7'h00;
          state_d = ofc_pkg::OFC_FIN;
        end else begin
          cnt_d = cnt_q + 7'h01;
        end
      end
      ofc_pkg::OFC_FIN: begin
        // last word lands now, so the selected sections are complete
        done = 1'b1;
        hdr_clr = xfer_q.rd_hdr; // RULE_12
        pay_clr = xfer_q.rd_pay; // RULE_12
        state_d = ofc_pkg::OFC_IDLE;
      end
      default: begin
        state_d = ofc_pkg::OFC_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ofc_pkg::OFC_IDLE;
      xfer_q <= '0;
      cnt_q <= 7'h00;
      pend_q <= 1'b0;
      pend_idx_q <= 7'h00;
    end else begin
      state_q <= state_d;
      xfer_q <= xfer_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      pend_idx_q <= pend_idx_d;
    end
  end

  // a full fetch ends in a bounded time and clears both flags
  a_full_copy_time: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
    (start && state_q == ofc_pkg::OFC_IDLE && xfer.rd_hdr && xfer.rd_pay)
      |-> ##[CL:CL] (done && hdr_clr && pay_clr))
    else $error("full copy did not finish on time");
  a_no_clear_unsel: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_12
    pay_clr |-> ($past(state_q) == ofc_pkg::OFC_PAY))
    else $error("new data flag cleared for unselected payload");

endmodule : ofc_copy_engine

/* File: logic/ofc_fetch_ctrl.sv */
// output fetch control: register slave, staging halves and swap logic
// What this block does
// RULE_01: writing request one starts copying the chosen buffer into the shadow half
// RULE_02: a request is taken only while busy reads zero
// RULE_03: busy sets on a taken request and clears when the copy ends
// RULE_04: writing view one while idle swaps host and shadow halves
// RULE_05: view and request together swap, then fetch into the new shadow half
// RULE_06: writes to staging registers while busy change nothing and raise an error
// RULE_07: the shadow request number is seven bits, buffers 0 to 127
// RULE_08: the receive FIFO's first number redirects the fetch to the FIFO read pointer
// RULE_09: a read-only host number follows the shadow number on every swap
// RULE_10: unused command bits read zero and the register resets to zero
// RULE_11: a swap also exchanges host and shadow header and payload select bits
// RULE_12: copied header clears the changed flag, copied payload clears new data
`timescale 1ns/1ps
`include "ofc_params.svh"

module ofc_fetch_ctrl #(
  parameter int HDR_WORDS = `OFC_HDR_WORDS,
  parameter int PAY_WORDS = `OFC_PAY_WORDS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // message memory read port
  output logic mem_rd_en,
  output logic [6:0] mem_rd_buf,
  output logic [6:0] mem_rd_word,
  input wire logic [31:0] mem_rd_data,
  // receive fifo
  input wire logic [6:0] fifo_read_pointer,
  // buffer flag clear pulses, buffer number on mem_rd_buf
  output logic buffer_changed_flag_clr,
  output logic new_data_flag_clr,
  // interrupt
  output logic irq
);

  localparam int DEPTH = HDR_WORDS + PAY_WORDS;

  // command and mask state
  logic [6:0] shadow_req_q, shadow_req_d;
  logic [6:0] host_num_q, host_num_d;
  logic [6:0] shadow_num_q, shadow_num_d;
  logic busy_q, busy_d;
  logic host_half_q, host_half_d;
  logic hdr_sh_q, hdr_sh_d, pay_sh_q, pay_sh_d;
  logic hdr_host_q, hdr_host_d, pay_host_q, pay_host_d;
  logic [6:0] fifo_first_q, fifo_first_d;
  // interrupt state
  logic [1:0] err_stat_q, err_stat_d, err_en_q, err_en_d;
  logic [1:0] err_set, err_clr;
  // bus state
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // staging halves, index 0 header then payload
  logic [31:0] stage_q [0:1][0:DEPTH-1];
  logic [31:0] stage_d [0:1][0:DEPTH-1];
  // glue
  logic wr_fire, rd_fire, start, swap;
  logic [31:0] wd;
  logic [7:0] wslot, rslot;
  logic [6:0] src, req_num;
  ofc_pkg::ofc_xfer_t xfer;
  ofc_pkg::ofc_stage_wr_t stage_wr;
  logic eng_done;

  // staging readout decode: bit 7 hit, low bits word index
  function automatic logic [7:0] stage_slot(input logic [11:0] a);
    logic [11:0] off_p;
    logic [11:0] off_h;
    off_p = a - `OFC_PAY_BASE;
    off_h = a - `OFC_HDR_BASE;
    stage_slot = 8'h00;
    if (a >= `OFC_PAY_BASE && off_p[11:2] < 10'(PAY_WORDS)) begin
      stage_slot = {1'b1, 7'(HDR_WORDS) + off_p[8:2]};
    end else if (a >= `OFC_HDR_BASE && off_h[11:2] < 10'(HDR_WORDS)) begin
      stage_slot = {1'b1, off_h[8:2]};
    end
  endfunction : stage_slot

  // byte-lane mask from write strobes
  function automatic logic [31:0] lanes(input logic [3:0] s);
    lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lanes

  // both write channels are taken together, one write in flight
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign wd = s_axi_wdata & lanes(s_axi_wstrb);
  assign wslot = stage_slot(s_axi_awaddr);
  assign rslot = stage_slot(s_axi_araddr);
  assign irq = |(err_stat_q & err_en_q);
  // fifo head request is redirected; decoded apart from the write process to avoid a loop
  assign req_num = (wr_fire && s_axi_awaddr == `OFC_CMD_OFF && s_axi_wstrb[0]) ?
    wd[6:0] : shadow_req_q;
  assign src = (req_num == fifo_first_q) ? fifo_read_pointer : req_num; // RULE_08

  // register writes, swap and fetch start
  always_comb begin
    shadow_req_d = shadow_req_q;
    host_num_d = host_num_q;
    shadow_num_d = shadow_num_q;
    busy_d = busy_q;
    host_half_d = host_half_q;
    hdr_sh_d = hdr_sh_q;
    pay_sh_d = pay_sh_q;
    hdr_host_d = hdr_host_q;
    pay_host_d = pay_host_q;
    fifo_first_d = fifo_first_q;
    err_en_d = err_en_q;
    err_set = 2'h0;
    err_clr = 2'h0;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    start = 1'b0;
    swap = 1'b0;
    xfer = '{buf_num: src, rd_hdr: hdr_sh_q, rd_pay: pay_sh_q};
    err_set[`OFC_ERR_DONE_BIT] = eng_done;
    if (eng_done) begin
      busy_d = 1'b0; // RULE_03
    end
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d = `OFC_RESP_OKAY;
      case (s_axi_awaddr)
        `OFC_CMD_OFF: begin
          if (busy_q) begin
            err_set[`OFC_ERR_ILLEGAL_BIT] = 1'b1; // RULE_02
          end else begin
            if (s_axi_wstrb[0]) begin
              shadow_req_d = wd[6:0]; // RULE_07
            end
            if (wd[`OFC_VIEW_BIT]) begin
              // masks travel with their halves
              swap = 1'b1; // RULE_04
              host_half_d = !host_half_q;
              host_num_d = shadow_num_q; // RULE_09
              shadow_num_d = host_num_q;
              hdr_host_d = hdr_sh_q; // RULE_11
              pay_host_d = pay_sh_q;
              hdr_sh_d = hdr_host_q;
              pay_sh_d = pay_host_q;
            end
            if (wd[`OFC_REQ_BIT]) begin
              // fetch into whichever half is shadow after any swap
              start = 1'b1; // RULE_01 RULE_05
              busy_d = 1'b1; // RULE_03
              shadow_num_d = src;
            end
          end
        end
        `OFC_MASK_OFF: begin
          if (busy_q) begin
            err_set[`OFC_ERR_ILLEGAL_BIT] = 1'b1; // RULE_06
          end else if (s_axi_wstrb[0]) begin
            hdr_sh_d = wd[`OFC_HDR_SH_BIT];
            pay_sh_d = wd[`OFC_PAY_SH_BIT];
          end
        end
        `OFC_ERR_STAT_OFF: begin
          bresp_d = `OFC_RESP_OKAY;
        end
        `OFC_ERR_CLR_OFF: begin
          err_clr = wd[1:0];
        end
        `OFC_ERR_EN_OFF: begin
          if (s_axi_wstrb[0]) begin
            err_en_d = wd[1:0];
          end
        end
        `OFC_FIFO_FIRST_OFF: begin
          if (s_axi_wstrb[0]) begin
            fifo_first_d = wd[6:0];
          end
        end
        default: begin
          // readout words are read-only; busy writes still flag
          if (wslot[7]) begin
            err_set[`OFC_ERR_ILLEGAL_BIT] = busy_q; // RULE_06
          end else begin
            bresp_d = `OFC_RESP_DECERR;
          end
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    err_stat_d = (err_stat_q & ~err_clr) | err_set;
  end

  // shadow half takes copied words; the halves only swap while idle
  always_comb begin
    stage_d = stage_q;
    if (stage_wr.we) begin
      stage_d[!host_half_q][stage_wr.idx] = stage_wr.data; // RULE_01
    end
  end

  // register reads, host half only
  always_comb begin
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d = `OFC_RESP_OKAY;
      rdata_d = `OFC_REG_RST;
      case (s_axi_araddr)
        `OFC_CMD_OFF: begin
          rdata_d[6:0] = shadow_req_q; // RULE_10
          rdata_d[`OFC_BUSY_BIT] = busy_q;
          rdata_d[`OFC_HOST_NUM_LSB +: `OFC_NUM_W] = host_num_q; // RULE_09
        end
        `OFC_MASK_OFF: begin
          rdata_d[`OFC_HDR_SH_BIT] = hdr_sh_q;
          rdata_d[`OFC_PAY_SH_BIT] = pay_sh_q;
          rdata_d[`OFC_HDR_HOST_BIT] = hdr_host_q;
          rdata_d[`OFC_PAY_HOST_BIT] = pay_host_q;
        end
        `OFC_ERR_STAT_OFF: rdata_d[1:0] = err_stat_q;
        `OFC_ERR_CLR_OFF: rdata_d = `OFC_REG_RST;
        `OFC_ERR_EN_OFF: rdata_d[1:0] = err_en_q;
        `OFC_FIFO_FIRST_OFF: rdata_d[6:0] = fifo_first_q;
        default: begin
          if (rslot[7]) begin
            rdata_d = stage_q[host_half_q][rslot[6:0]];
          end else begin
            rresp_d = `OFC_RESP_DECERR;
          end
        end
      endcase
    end
  end

  // all registers, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_req_q <= 7'h00; // RULE_10
      host_num_q <= 7'h00;
      shadow_num_q <= 7'h00;
      busy_q <= 1'b0;
      host_half_q <= 1'b0;
      {hdr_sh_q, pay_sh_q, hdr_host_q, pay_host_q} <= 4'h0;
      fifo_first_q <= `OFC_FIFO_FIRST_RST;
      err_stat_q <= 2'h0;
      err_en_q <= 2'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `OFC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `OFC_RESP_OKAY;
      rdata_q <= `OFC_REG_RST;
      stage_q <= '{default: '{default: 32'h0000_0000}};
    end else begin
      shadow_req_q <= shadow_req_d;
      host_num_q <= host_num_d;
      shadow_num_q <= shadow_num_d;
      busy_q <= busy_d;
      host_half_q <= host_half_d;
      {hdr_sh_q, pay_sh_q, hdr_host_q, pay_host_q} <= {hdr_sh_d, pay_sh_d, hdr_host_d, pay_host_d};
      fifo_first_q <= fifo_first_d;
      err_stat_q <= err_stat_d;
      err_en_q <= err_en_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      stage_q <= stage_d;
    end
  end

  // copy sequencer
  ofc_copy_engine #(
    .HDR_WORDS(HDR_WORDS),
    .PAY_WORDS(PAY_WORDS)
  ) u_copy (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start),
    .xfer(xfer),
    .mem_rd_en(mem_rd_en),
    .mem_rd_buf(mem_rd_buf),
    .mem_rd_word(mem_rd_word),
    .mem_rd_data(mem_rd_data),
    .stage_wr(stage_wr),
    .done(eng_done),
    .hdr_clr(buffer_changed_flag_clr),
    .pay_clr(new_data_flag_clr)
  );

  // checks on the command path
  a_req_sets_busy: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_01
    (wr_fire && s_axi_awaddr == `OFC_CMD_OFF && !busy_q && wd[`OFC_REQ_BIT]) |=> busy_q)
    else $error("request did not set busy");
  a_busy_no_start: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
    busy_q |-> !start)
    else $error("fetch started while busy");
  a_busy_until_done: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
    (busy_q && !eng_done) |=> busy_q)
    else $error("busy dropped before copy done");
  a_view_swaps: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
    swap |=> (host_half_q != $past(host_half_q)))
    else $error("view did not swap halves");
  a_view_and_req: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
    (swap && start) |=> (busy_q && mem_rd_buf == $past(src)))
    else $error("swap with request did not fetch");
  a_busy_write_err: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06
    (wr_fire && busy_q && s_axi_awaddr == `OFC_CMD_OFF)
      |=> (err_stat_q[`OFC_ERR_ILLEGAL_BIT] && $stable(shadow_req_q) && $stable(host_half_q)))
    else $error("busy write not rejected");
  a_fifo_redirect: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    (start && req_num == fifo_first_q) |=> (shadow_num_q == $past(fifo_read_pointer)))
    else $error("fifo head not redirected");
  a_host_number: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
    swap |=> (host_num_q == $past(shadow_num_q)))
    else $error("host number not taken on swap");
  a_mask_swap: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_11
    swap |=> (hdr_host_q == $past(hdr_sh_q) && pay_host_q == $past(pay_sh_q)))
    else $error("select bits not swapped");
  a_cmd_zero_bits: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
    (rd_fire && s_axi_araddr == `OFC_CMD_OFF) |=> (rdata_q[14:7] == 8'h00))
    else $error("unused command bits not zero");

endmodule : ofc_fetch_ctrl

/* File: testbench/ofc_msg_mem_model.sv */
// message memory model answering the copy sequencer's read strobes
`timescale 1ns/1ps

module ofc_msg_mem_model (
  // clock
  input wire logic aclk,
  // read port
  input wire logic rd_en,
  input wire logic [6:0] rd_buf,
  input wire logic [6:0] rd_word,
  output logic [31:0] rd_data
);
  // word one cycle after the strobe; each idle cycle inverts the word shown
  // so a sequencer that samples one cycle late never sees a plausible stale value
  always @(posedge aclk) begin
    if (rd_en === 1'b1) begin
      rd_data <= {8'hC3, 1'b0, rd_buf, 9'h000, rd_word};
    end else begin
      rd_data <= ~rd_data;
    end
  end

  // defined start value
  initial rd_data = 32'h0000_0000;
endmodule : ofc_msg_mem_model

/* File: testbench/ofc_fetch_ctrl_tb_top.sv */
// self-checking bench of the output fetch control block
`timescale 1ns/1ps
`include "ofc_params.svh"

module ofc_fetch_ctrl_tb_top;
  logic aclk;
  logic aresetn;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic awvalid, wvalid, arvalid;
  logic [31:0] wdata;
  logic [6:0] fifo_ptr;
  logic [3:0] wstrb;
  logic bready, rready;
  logic awready, wready, bvalid, arready, rvalid, mem_en, chg_clr, nd_clr, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, mem_data, rv;
  logic [6:0] mem_buf, mem_word, clr_buf;
  logic [1:0] rs;
  int num_errors, cmp_count, strobes;

  ofc_fetch_ctrl #(.HDR_WORDS(3), .PAY_WORDS(64)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mem_rd_en(mem_en), .mem_rd_buf(mem_buf),
    .mem_rd_word(mem_word), .mem_rd_data(mem_data), .fifo_read_pointer(fifo_ptr),
    .buffer_changed_flag_clr(chg_clr), .new_data_flag_clr(nd_clr), .irq(irq)
  );

  ofc_msg_mem_model mem_u (
    .aclk(aclk), .rd_en(mem_en), .rd_buf(mem_buf), .rd_word(mem_word),
    .rd_data(mem_data)
  );

  // clock
  always #2 aclk = ~aclk;

  // count copy strobes, note the buffer whose header and payload flags both get cleared
  always @(posedge aclk) begin
    if (mem_en === 1'b1) strobes <= strobes + 1;
    if (chg_clr === 1'b1 && nd_clr === 1'b1) clr_buf <= mem_buf;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] pat(input logic [6:0] b, input logic [6:0] w);
    return {8'hC3, 1'b0, b, 9'h000, w};
  endfunction : pat

  // bus tasks are entered just after a rising edge; bready/rready stay high
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(negedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
    @(posedge aclk);
  endtask : rd

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask : rdc

  // poll busy; the watchdog bounds a hang
  task automatic wait_idle;
    do rd(`OFC_CMD_OFF); while (rv[`OFC_BUSY_BIT] !== 1'b0);
  endtask : wait_idle

  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge aclk);
  endtask : chk_irq

  task automatic t_reset;
    rdc(`OFC_CMD_OFF, 32'h0000_0000);
    rdc(`OFC_MASK_OFF, 32'h0000_0000);
    rd(12'h7F0);
    chk({30'h0, rs}, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fetch;
    wr(`OFC_MASK_OFF, 32'h0000_0003);
    wr(`OFC_CMD_OFF, 32'h0000_0205);
    rdc(`OFC_CMD_OFF, 32'h0000_8005);
    wr(`OFC_CMD_OFF, 32'h0000_0209);
    chk({30'h0, rs}, 32'h0000_0000);
    wait_idle();
    rdc(`OFC_CMD_OFF, 32'h0000_0005);
    chk(32'(strobes), 32'h0000_0043);
    chk({25'h0, clr_buf}, 32'h0000_0005);
    rdc(`OFC_ERR_STAT_OFF, 32'h0000_0003);
    fifo_ptr <= 7'h21;
    wr(`OFC_CMD_OFF, 32'h0000_037F);
    rdc(`OFC_CMD_OFF, 32'h0005_807F);
    rdc(`OFC_MASK_OFF, 32'h0003_0000);
    rdc(`OFC_HDR_BASE, pat(7'h05, 7'h00));
    rdc(12'h708, pat(7'h05, 7'h02));
    rdc(`OFC_PAY_BASE, pat(7'h05, 7'h03));
    rdc(12'h6FC, pat(7'h05, 7'h42));
    wait_idle();
    chk({25'h0, clr_buf}, 32'h0000_0021);
    chk(32'(strobes), 32'h0000_0086);
    wr(`OFC_CMD_OFF, 32'h0000_0100);
    rdc(`OFC_CMD_OFF, 32'h0021_0000);
    rdc(`OFC_MASK_OFF, 32'h0000_0003);
    rdc(`OFC_PAY_BASE, pat(7'h21, 7'h03));
    $display("test fetch done");
  endtask : t_fetch

  task automatic t_irq;
    wr(`OFC_ERR_EN_OFF, 32'h0000_0001);
    chk_irq(1'b1);
    wr(`OFC_ERR_CLR_OFF, 32'h0000_0001);
    chk_irq(1'b0);
    rdc(`OFC_ERR_STAT_OFF, 32'h0000_0002);
    wr(`OFC_ERR_EN_OFF, 32'h0000_0003);
    chk_irq(1'b1);
    wr(`OFC_ERR_CLR_OFF, 32'h0000_0002);
    chk_irq(1'b0);
    $display("test irq done");
  endtask : t_irq

  // header-only fetch written on lane 1 alone: the request number must not move
  task automatic t_lanes;
    wr(`OFC_MASK_OFF, 32'h0000_0001);
    wstrb <= 4'h2;
    wr(`OFC_CMD_OFF, 32'h0000_0245);
    wstrb <= 4'hF;
    wait_idle();
    chk(32'(strobes), 32'h0000_0089);
    rdc(`OFC_CMD_OFF, 32'h0021_0000);
    chk_irq(1'b1);
    $display("test lanes done");
  endtask : t_lanes

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    bready = 1'b1;
    rready = 1'b1;
    fifo_ptr = 7'h00;
    clr_buf = 7'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_fetch();
    t_irq();
    t_lanes();
    final_report();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    final_report();
  end
endmodule : ofc_fetch_ctrl_tb_top
